// ==== shared/ars_pkg.sv ====
// Constants of the rounded-store, sign-extend and fill-ones datapath.
// Assumes a 24-bit instruction word and a 16-bit working register file.
package ars_pkg;
    // Opcode byte, bits 23:16 of the instruction word
    localparam logic [7:0] OPC_STORE_ROUND = 8'hCD;
    localparam logic [7:0] OPC_SIGN_EXT = 8'hFB;
    localparam logic [7:0] OPC_FILL_ONES = 8'hEF;
    localparam int OPC_MSB = 23;
    localparam int OPC_LSB = 16;
    // Field positions
    localparam int ACC_SEL_BIT = 15;
    localparam int FILL_SIZE_BIT = 14;
    localparam int FILL_DEST_BIT = 13;
    localparam int FILE_ADDR_MSB = 12;
    localparam int EXT_ZERO_MSB = 15;
    localparam int EXT_ZERO_LSB = 11;
    // Core control register bits
    localparam int ROUND_MODE_POS = 1;
    localparam int SAT_DW_POS = 5;
    // Rounding-mode bit value meaning conventional rounding
    localparam logic ROUND_CONV_VALUE = 1'b1;
    // Address modes of the 3-bit mode field
    localparam logic [2:0] AM_DIRECT = 3'h0;
    localparam logic [2:0] AM_IND = 3'h1;
    localparam logic [2:0] AM_POSTDEC = 3'h2;
    localparam logic [2:0] AM_POSTINC = 3'h3;
    localparam logic [2:0] AM_PREDEC = 3'h4;
    localparam logic [2:0] AM_PREINC = 3'h5;
    // Pointer steps in bytes
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    // Default working register index and fill values
    localparam logic [3:0] DEFAULT_REG_IDX = 4'h0;
    localparam logic [15:0] ONES_WORD = 16'hFFFF;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    // Saturation limits of the stored word and rounding half-LSB constants
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam logic [39:0] ROUND_HALF = 40'h00_0000_8000;
    localparam logic [15:0] HALF_LSB = 16'h8000;
endpackage

// ==== shared/ars_dp_if.sv ====
// Bundle between the controller and its rounding and sign-extension units.
// All signals are combinational within one core clock cycle.
`timescale 1ns/1ps
interface ars_dp_if;
    logic [39:0] acc; // Selected accumulator
    logic [3:0] shift; // Signed pre-shift literal
    logic rmode; // Rounding-mode bit
    logic sat_en; // Data-write saturation enable
    logic [15:0] round_word; // Rounded, saturated upper word
    logic [7:0] ext_byte; // Byte to extend
    logic [15:0] ext_word; // Extended word
    logic [2:0] ext_nzc; // Negative, zero, carry
    modport ctrl (output acc, shift, rmode, sat_en, ext_byte,
        input round_word, ext_word, ext_nzc);
    modport rounder (input acc, shift, rmode, sat_en, output round_word);
    modport extender (input ext_byte, output ext_word, ext_nzc);
endinterface

// ==== rtl/ars_round_unit.sv ====
// Shift, round and saturate of an accumulator to its upper word.
// Assumes the controller presents a 40-bit accumulator and control bits.
`timescale 1ns/1ps
module ars_round_unit (
    ars_dp_if.rounder dp // Operands and result
);
    logic [39:0] shifted; // Accumulator after pre-shift
    logic [39:0] rounded; // After rounding
    logic [3:0] mag; // Left-shift magnitude

    // Negative literal shifts left, positive shifts right
    always_comb begin
        mag = 4'(-dp.shift);
        if (dp.shift[3]) begin
            shifted = dp.acc << mag;
        end else begin
            shifted = 40'($signed(dp.acc) >>> dp.shift);
        end
    end

    // Conventional adds one half; convergent ties round to even
    always_comb begin
        if (dp.rmode != ars_pkg::ROUND_CONV_VALUE && shifted[15:0] == ars_pkg::HALF_LSB) begin
            rounded = shifted + (shifted[16] ? ars_pkg::ROUND_HALF : 40'h0);
        end else begin
            rounded = shifted + ars_pkg::ROUND_HALF;
        end
    end

    // Upper word, clamped when the guard bits disagree
    always_comb begin
        if (dp.sat_en && !(&rounded[39:31] || ~|rounded[39:31])) begin
            dp.round_word = rounded[39] ? ars_pkg::SAT_NEG : ars_pkg::SAT_POS;
        end else begin
            dp.round_word = rounded[31:16];
        end
    end
endmodule // ars_round_unit

// ==== rtl/ars_signext_unit.sv ====
// Byte to word sign extension with its status flags.
// Assumes the controller supplies the source byte already fetched.
`timescale 1ns/1ps
module ars_signext_unit (
    ars_dp_if.extender dp // Operands and result
);
    // Copy low byte, fill high byte from bit 7, carry is not negative
    always_comb begin
        dp.ext_word = {(dp.ext_byte[7] ? ars_pkg::ONES_BYTE : 8'h00), dp.ext_byte};
        dp.ext_nzc = {dp.ext_word[15], dp.ext_word == 16'h0000, ~dp.ext_word[15]};
    end
endmodule // ars_signext_unit

// ==== rtl/ars_exec.sv ====
// Execution datapath for rounded accumulator store, sign extend, fill ones.
// Assumes the sequencer presents one instruction with its operands per cycle
// and applies the registered write requests one cycle later.
`timescale 1ns/1ps
module ars_exec (
    input wire logic clock_in, // Core clock, 100 MHz
    input wire logic resetn_in, // Asynchronous reset, active low
    input wire logic instr_valid_in, // Instruction present this cycle
    input wire logic [23:0] instr_word_in, // Instruction word
    input wire logic [15:0] reg_lo_in, // Value of W selected by bits 3:0
    input wire logic [15:0] reg_off_in, // Value of W selected by bits 14:11
    input wire logic [15:0] mem_rdata_in, // Source data at extend address
    input wire logic [39:0] accumulator_a_in, // Accumulator A
    input wire logic [39:0] accumulator_b_in, // Accumulator B
    input wire logic [15:0] core_control_reg_in, // Core control register
    output logic done_out, // Operation completed pulse
    output logic unsupported_out, // Unrecognised word pulse
    output logic reg_we_out, // Register write strobe
    output logic [3:0] reg_addr_out, // Register index
    output logic [15:0] reg_data_out, // Register write data
    output logic reg_byte_out, // Write low byte only
    output logic ptr_we_out, // Pointer update strobe
    output logic [3:0] ptr_addr_out, // Pointer register index
    output logic [15:0] ptr_data_out, // New pointer value
    output logic mem_we_out, // Memory write strobe
    output logic [15:0] mem_addr_out, // Memory byte address
    output logic [15:0] mem_data_out, // Memory write data
    output logic mem_byte_out, // Memory byte write
    output logic flag_we_out, // Flag update strobe
    output logic [2:0] flags_nzc_out // Negative, zero, carry
);
    // All registered state of the block
    typedef struct packed {
        logic done;
        logic bad;
        logic reg_we;
        logic [3:0] reg_addr;
        logic [15:0] reg_data;
        logic reg_byte;
        logic ptr_we;
        logic [3:0] ptr_addr;
        logic [15:0] ptr_data;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [15:0] mem_data;
        logic mem_byte;
        logic flag_we;
        logic [2:0] flags;
    } ars_state_t;

    ars_state_t st_q; // Current state
    ars_state_t st_d; // Next state
    ars_dp_if dp (); // Link to arithmetic units
    logic [7:0] opc; // Opcode byte
    logic is_store; // Rounded store decoded
    logic is_ext; // Sign extend decoded
    logic is_fill; // Fill ones decoded
    logic [2:0] mode; // Address mode field
    logic [32:0] ea; // Pointer update, new pointer, address

    // Effective address: {pointer write, new pointer, access address}
    function automatic logic [32:0] ars_ea(input logic [2:0] am, input logic [15:0] base,
            input logic [15:0] off, input logic [15:0] step);
        logic [32:0] r;
        r = {1'b0, base, base};
        unique case (am)
            ars_pkg::AM_IND: r = {1'b0, base, base};
            ars_pkg::AM_POSTDEC: r = {1'b1, 16'(base - step), base};
            ars_pkg::AM_POSTINC: r = {1'b1, 16'(base + step), base};
            ars_pkg::AM_PREDEC: r = {1'b1, 16'(base - step), 16'(base - step)};
            ars_pkg::AM_PREINC: r = {1'b1, 16'(base + step), 16'(base + step)};
            default: r = {1'b0, base, 16'(base + off)};
        endcase
        return r;
    endfunction

    // Rounding path
    ars_round_unit u_round (
        .dp(dp.rounder)
    );

    // Sign extension path
    ars_signext_unit u_ext (
        .dp(dp.extender)
    );

    // Opcode decode
    always_comb begin
        opc = instr_word_in[ars_pkg::OPC_MSB:ars_pkg::OPC_LSB];
        is_store = instr_valid_in && opc == ars_pkg::OPC_STORE_ROUND;
        is_ext = instr_valid_in && opc == ars_pkg::OPC_SIGN_EXT
            && instr_word_in[ars_pkg::EXT_ZERO_MSB:ars_pkg::EXT_ZERO_LSB] == 5'h00;
        is_fill = instr_valid_in && opc == ars_pkg::OPC_FILL_ONES
            && instr_word_in[ars_pkg::ACC_SEL_BIT];
        mode = instr_word_in[6:4];
    end

    // Operands to the arithmetic units
    always_comb begin
        dp.acc = instr_word_in[ars_pkg::ACC_SEL_BIT] ? accumulator_b_in : accumulator_a_in;
        dp.shift = instr_word_in[10:7];
        dp.rmode = core_control_reg_in[ars_pkg::ROUND_MODE_POS];
        dp.sat_en = core_control_reg_in[ars_pkg::SAT_DW_POS];
        dp.ext_byte = (mode == ars_pkg::AM_DIRECT) ? reg_lo_in[7:0] : mem_rdata_in[7:0];
    end

    // Next state: one instruction finishes per cycle
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.bad = 1'b0;
        st_d.reg_we = 1'b0;
        st_d.ptr_we = 1'b0;
        st_d.mem_we = 1'b0;
        st_d.flag_we = 1'b0;
        ea = ars_ea(mode, reg_lo_in, reg_off_in,
            is_ext ? ars_pkg::STEP_BYTE : ars_pkg::STEP_WORD);
        if (is_store) begin
            // Accumulator has no write path here
            st_d.done = 1'b1;
            if (mode == ars_pkg::AM_DIRECT) begin
                st_d.reg_we = 1'b1;
                st_d.reg_addr = instr_word_in[3:0];
                st_d.reg_data = dp.round_word;
                st_d.reg_byte = 1'b0;
            end else begin
                st_d.mem_we = 1'b1;
                st_d.mem_addr = ea[15:0];
                st_d.mem_data = dp.round_word;
                st_d.mem_byte = 1'b0;
                st_d.ptr_we = ea[32];
                st_d.ptr_addr = instr_word_in[3:0];
                st_d.ptr_data = ea[31:16];
            end
        end else if (is_ext) begin
            if (mode[2:1] == 2'b11) begin
                st_d.bad = 1'b1; // No offset mode for the source
            end else begin
                st_d.done = 1'b1;
                st_d.reg_we = 1'b1;
                st_d.reg_addr = instr_word_in[10:7];
                st_d.reg_data = dp.ext_word;
                st_d.reg_byte = 1'b0;
                st_d.flag_we = 1'b1;
                st_d.flags = dp.ext_nzc;
                st_d.ptr_we = ea[32]; // Source pointer steps by one byte
                st_d.ptr_addr = instr_word_in[3:0];
                st_d.ptr_data = ea[31:16];
            end
        end else if (is_fill) begin
            st_d.done = 1'b1;
            if (instr_word_in[ars_pkg::FILL_DEST_BIT]) begin
                st_d.mem_we = 1'b1;
                st_d.mem_addr = {3'h0, instr_word_in[ars_pkg::FILE_ADDR_MSB:0]};
                st_d.mem_data = ars_pkg::ONES_WORD;
                st_d.mem_byte = instr_word_in[ars_pkg::FILL_SIZE_BIT];
            end else begin
                st_d.reg_we = 1'b1;
                st_d.reg_addr = ars_pkg::DEFAULT_REG_IDX;
                st_d.reg_data = ars_pkg::ONES_WORD;
                st_d.reg_byte = instr_word_in[ars_pkg::FILL_SIZE_BIT];
            end
        end else if (instr_valid_in) begin
            st_d.bad = 1'b1; // Word for another unit
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign done_out = st_q.done;
    assign unsupported_out = st_q.bad;
    assign reg_we_out = st_q.reg_we;
    assign reg_addr_out = st_q.reg_addr;
    assign reg_data_out = st_q.reg_data;
    assign reg_byte_out = st_q.reg_byte;
    assign ptr_we_out = st_q.ptr_we;
    assign ptr_addr_out = st_q.ptr_addr;
    assign ptr_data_out = st_q.ptr_data;
    assign mem_we_out = st_q.mem_we;
    assign mem_addr_out = st_q.mem_addr;
    assign mem_data_out = st_q.mem_data;
    assign mem_byte_out = st_q.mem_byte;
    assign flag_we_out = st_q.flag_we;
    assign flags_nzc_out = st_q.flags;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    // Store issued with given mode
    sequence s_store(logic [2:0] m);
        instr_valid_in && opc == ars_pkg::OPC_STORE_ROUND && mode == m;
    endsequence
    // Plain store: no shift, no saturation, conventional rounding
    sequence s_plain_store;
        s_store(ars_pkg::AM_DIRECT) ##0 (instr_word_in[10:7] == 4'h0
            && !core_control_reg_in[ars_pkg::SAT_DW_POS]
            && core_control_reg_in[ars_pkg::ROUND_MODE_POS] == ars_pkg::ROUND_CONV_VALUE);
    endsequence

    a_store_one_cycle: assert property (
        s_store(ars_pkg::AM_IND) |=> done_out && mem_we_out && !reg_we_out
            ##1 (done_out || unsupported_out) == $past(instr_valid_in))
        else $error("store did not finish in one cycle");
    a_post_inc_two: assert property (
        s_store(ars_pkg::AM_POSTINC) |=> ptr_we_out
            && ptr_data_out == 16'($past(reg_lo_in) + 16'h0002)
            && mem_addr_out == $past(reg_lo_in))
        else $error("post-increment did not step by two");
    a_round_conv: assert property (
        s_plain_store |=> reg_data_out == 16'($past(dp.acc[31:16]) + {15'h0, $past(dp.acc[15])}))
        else $error("conventional rounding wrong");
    a_sat_positive: assert property (
        s_store(ars_pkg::AM_DIRECT) ##0 (instr_word_in[10:7] == 4'h0
            && core_control_reg_in[ars_pkg::SAT_DW_POS] && !dp.acc[39] && dp.acc[38:31] != 8'h00)
        |=> reg_data_out == ars_pkg::SAT_POS)
        else $error("positive saturation missing");
    a_shift_left_max: assert property (
        s_store(ars_pkg::AM_DIRECT) ##0 (instr_word_in[10:7] == 4'h8
            && !core_control_reg_in[ars_pkg::SAT_DW_POS]
            && core_control_reg_in[ars_pkg::ROUND_MODE_POS] == ars_pkg::ROUND_CONV_VALUE)
        |=> reg_data_out == 16'($past(dp.acc[23:8]) + {15'h0, $past(dp.acc[7])}))
        else $error("left shift by eight wrong");
    a_ext_fill: assert property (
        instr_valid_in && opc == ars_pkg::OPC_SIGN_EXT && mode == ars_pkg::AM_DIRECT
            && instr_word_in[15:11] == 5'h00
        |=> reg_data_out == {{8{$past(reg_lo_in[7])}}, $past(reg_lo_in[7:0])})
        else $error("sign extension wrong");
    a_ext_carry: assert property (
        flag_we_out |-> flags_nzc_out[0] == !flags_nzc_out[2]
            && flags_nzc_out[2] == reg_data_out[15])
        else $error("extend flags wrong");
    a_ext_dest_reg: assert property (
        instr_valid_in && opc == ars_pkg::OPC_SIGN_EXT && instr_word_in[15:11] == 5'h00
            && mode[2:1] != 2'b11
        |=> reg_we_out && !mem_we_out && reg_addr_out == $past(instr_word_in[10:7]))
        else $error("extend destination not a register");
    a_fill_default: assert property (
        is_fill && !instr_word_in[ars_pkg::FILL_DEST_BIT]
        |=> reg_we_out && reg_addr_out == ars_pkg::DEFAULT_REG_IDX && reg_data_out == 16'hFFFF
            && reg_byte_out == $past(instr_word_in[ars_pkg::FILL_SIZE_BIT]))
        else $error("fill of default register wrong");
    a_no_flags: assert property (
        instr_valid_in && (opc == ars_pkg::OPC_STORE_ROUND || opc == ars_pkg::OPC_FILL_ONES)
        |=> !flag_we_out)
        else $error("flags touched by store or fill");
    a_bad_opcode: assert property (
        instr_valid_in && opc != ars_pkg::OPC_STORE_ROUND && opc != ars_pkg::OPC_SIGN_EXT
            && opc != ars_pkg::OPC_FILL_ONES |=> unsupported_out && !done_out)
        else $error("foreign opcode executed");
endmodule // ars_exec

// ==== tb/ars_seq_model.sv ====
// Behavioural sequencer and register file facing the execution datapath.
// Assumes the datapath's write strobes are registered one cycle after issue.
`timescale 1ns/1ps
module ars_seq_model (
    input wire logic clock_in, // Core clock
    input wire logic [23:0] instr_word_in, // Word on the instruction port
    input wire logic reg_we_in, // Register write strobe
    input wire logic [3:0] reg_addr_in, // Register index
    input wire logic [15:0] reg_data_in, // Register write data
    input wire logic reg_byte_in, // Low byte only
    input wire logic ptr_we_in, // Pointer update strobe
    input wire logic [3:0] ptr_addr_in, // Pointer index
    input wire logic [15:0] ptr_data_in, // New pointer value
    input wire logic mem_we_in, // Memory write strobe
    input wire logic [15:0] mem_addr_in, // Memory byte address
    input wire logic [15:0] mem_data_in, // Memory write data
    input wire logic mem_byte_in, // Byte write
    output logic [15:0] reg_lo_out, // Register picked by bits 3:0
    output logic [15:0] reg_off_out, // Register picked by bits 14:11
    output logic [15:0] mem_rdata_out // Data at extend source address
);
    logic [15:0] regs [16]; // Working registers
    logic [7:0] mem [256]; // Small byte memory, address wraps
    logic [7:0] ea; // Extend source byte address

    // Distinct start values so every register differs
    initial begin
        for (int i = 0; i < 16; i++) regs[i] = 16'(i) * 16'h1357;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    end

    // Operand fetch, source read at the effective address
    always_comb begin
        reg_lo_out = regs[instr_word_in[3:0]];
        reg_off_out = regs[instr_word_in[14:11]];
        case (instr_word_in[6:4])
            3'h4: ea = reg_lo_out[7:0] - 8'h01; // Pre-decrement by one byte
            3'h5: ea = reg_lo_out[7:0] + 8'h01; // Pre-increment by one byte
            default: ea = reg_lo_out[7:0];
        endcase
        mem_rdata_out = {mem[ea + 8'h01], mem[ea]};
    end

    // Apply write requests; data write wins over pointer to same register
    always @(posedge clock_in) begin
        if (ptr_we_in) regs[ptr_addr_in] <= ptr_data_in;
        if (reg_we_in && reg_byte_in) regs[reg_addr_in][7:0] <= reg_data_in[7:0];
        if (reg_we_in && !reg_byte_in) regs[reg_addr_in] <= reg_data_in;
        if (mem_we_in) mem[mem_addr_in[7:0]] <= mem_data_in[7:0];
        if (mem_we_in && !mem_byte_in) mem[mem_addr_in[7:0] + 8'h01] <= mem_data_in[15:8];
    end
endmodule // ars_seq_model

// ==== tb/acc_round_store_signext_fill_tb_top.sv ====
// Self-checking bench for the rounded store, sign extend and fill datapath.
// Assumes the sequencer model supplies operands and applies writes.
`timescale 1ns/1ps
module acc_round_store_signext_fill_tb_top;
    typedef struct packed {
        logic done, unsup, reg_we, ptr_we, mem_we, flag_we;
        logic [3:0] reg_addr;
        logic [15:0] reg_data;
        logic reg_byte;
        logic [3:0] ptr_addr;
        logic [15:0] ptr_data, mem_addr, mem_data;
        logic mem_byte;
        logic [2:0] nzc;
    } ars_exp_t; // Expected outputs of one instruction

    logic clock_in, resetn_in, instr_valid_in; // Clock, reset, valid
    logic [23:0] instr_word_in; // Instruction word
    logic [15:0] reg_lo_in, reg_off_in, mem_rdata_in, core_control_reg_in; // Operands
    logic [39:0] accumulator_a_in, accumulator_b_in; // Accumulators
    logic done_out, unsupported_out, reg_we_out, reg_byte_out, ptr_we_out; // Strobes
    logic mem_we_out, mem_byte_out, flag_we_out; // Strobes and size
    logic [3:0] reg_addr_out, ptr_addr_out; // Indices
    logic [15:0] reg_data_out, ptr_data_out, mem_addr_out, mem_data_out; // Data
    logic [2:0] flags_nzc_out; // Flags
    integer seed, bad_count, n_compared, cycles; // Seed and counters
    ars_exp_t e; // Pending expectation
    logic pend; // Instruction issued last edge
    logic [31:0] r; // Random draw
    logic [23:0] w; // Word under construction

    ars_exec i_dut (.clock_in(clock_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in),
        .instr_word_in(instr_word_in), .reg_lo_in(reg_lo_in), .reg_off_in(reg_off_in),
        .mem_rdata_in(mem_rdata_in), .accumulator_a_in(accumulator_a_in),
        .accumulator_b_in(accumulator_b_in), .core_control_reg_in(core_control_reg_in),
        .done_out(done_out), .unsupported_out(unsupported_out), .reg_we_out(reg_we_out),
        .reg_addr_out(reg_addr_out), .reg_data_out(reg_data_out), .reg_byte_out(reg_byte_out),
        .ptr_we_out(ptr_we_out), .ptr_addr_out(ptr_addr_out), .ptr_data_out(ptr_data_out),
        .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
        .mem_byte_out(mem_byte_out), .flag_we_out(flag_we_out), .flags_nzc_out(flags_nzc_out));

    ars_seq_model i_seq (.clock_in(clock_in), .instr_word_in(instr_word_in),
        .reg_we_in(reg_we_out), .reg_addr_in(reg_addr_out), .reg_data_in(reg_data_out),
        .reg_byte_in(reg_byte_out), .ptr_we_in(ptr_we_out), .ptr_addr_in(ptr_addr_out),
        .ptr_data_in(ptr_data_out), .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
        .mem_data_in(mem_data_out), .mem_byte_in(mem_byte_out), .reg_lo_out(reg_lo_in),
        .reg_off_out(reg_off_in), .mem_rdata_out(mem_rdata_in));

    // Shift, round, saturate to the stored upper word
    function automatic logic [15:0] exp_round(input logic [39:0] acc, input logic [3:0] sh,
        input logic conv, input logic sat);
        logic [39:0] v;
        logic [39:0] t;
        if (sh[3]) v = acc << (5'h10 - 5'(sh)); // Negative: left
        else v = 40'($signed(acc) >>> sh); // Positive: arithmetic right
        t = v + 40'h00_0000_8000;
        if (!conv && v[16:0] == 17'h08000) t = v; // Tie stays on even
        if (sat && r_disagree(t)) return t[39] ? 16'h8000 : 16'h7FFF;
        return t[31:16];
    endfunction

    // Upper bits do not all match the stored sign
    function automatic logic r_disagree(input logic [39:0] t);
        return t[39:31] != {9{t[39]}};
    endfunction

    // Expected outputs from the issued word and its operands
    function automatic ars_exp_t predict(input logic [23:0] x, input logic [15:0] lo, off, rd,
        input logic [39:0] aa, ab, input logic [15:0] cc);
        ars_exp_t q;
        logic [2:0] m;
        logic [15:0] v;
        q = '0;
        m = x[6:4];
        q.done = 1'h1;
        q.ptr_addr = x[3:0];
        if (x[23:16] == 8'hCD) begin
            v = exp_round(x[15] ? ab : aa, x[10:7], cc[1] === ars_pkg::ROUND_CONV_VALUE, cc[5]);
            q.ptr_we = m inside {[2:5]};
            q.ptr_data = (m == 3'h2 || m == 3'h4) ? lo - 16'h0002 : lo + 16'h0002;
            q.mem_data = v;
            q.reg_data = v;
            q.reg_addr = x[3:0];
            q.reg_we = (m == 3'h0);
            q.mem_we = (m != 3'h0);
            q.mem_addr = m[2:1] == 2'h3 ? lo + off : (m[2] ? q.ptr_data : lo);
        end else if (x[23:16] == 8'hFB && x[15:11] == 5'h00 && m[2:1] != 2'h3) begin
            v = (m == 3'h0) ? {{8{lo[7]}}, lo[7:0]} : {{8{rd[7]}}, rd[7:0]};
            q.reg_we = 1'h1;
            q.reg_addr = x[10:7];
            q.reg_data = v;
            q.flag_we = 1'h1;
            q.nzc = {v[15], v == 16'h0000, ~v[15]};
            q.ptr_we = m inside {[2:5]};
            q.ptr_data = (m == 3'h2 || m == 3'h4) ? lo - 16'h0001 : lo + 16'h0001;
        end else if (x[23:16] == 8'hEF && x[15]) begin
            q.reg_we = !x[13];
            q.reg_data = 16'hFFFF;
            q.reg_byte = x[14];
            q.mem_we = x[13];
            q.mem_addr = {3'h0, x[12:0]};
            q.mem_data = 16'hFFFF;
            q.mem_byte = x[14];
        end else begin
            q.done = 1'h0; // Refused word
            q.unsup = 1'h1;
        end
        return q;
    endfunction

    // Compare and count
    task automatic chk(input string name, input logic [95:0] exp, input logic [95:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run;
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Issue one word with its accumulators and control word
    task automatic iss(input logic [23:0] x, input logic [39:0] aa, ab, input logic [15:0] cc);
        @(posedge clock_in);
        instr_valid_in <= 1'h1;
        instr_word_in <= x;
        accumulator_a_in <= aa;
        accumulator_b_in <= ab;
        core_control_reg_in <= cc;
    endtask

    // Random 40-bit accumulator
    function automatic logic [39:0] r40();
        return {8'($random(seed)), 32'($random(seed))};
    endfunction

    // Clock
    initial begin
        clock_in = 1'h0;
        forever #5 clock_in = ~clock_in;
    end

    // Capture expectation at the taking edge
    always @(posedge clock_in) begin
        pend = resetn_in && instr_valid_in;
        if (pend) e = predict(instr_word_in, reg_lo_in, reg_off_in, mem_rdata_in,
            accumulator_a_in, accumulator_b_in, core_control_reg_in);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // Check the answer one cycle later, strobes idle otherwise
    always @(negedge clock_in) begin
        if (resetn_in) begin
            chk("strobes", pend ? {e.done, e.unsup, e.reg_we, e.ptr_we, e.mem_we, e.flag_we} : 6'h00,
                {done_out, unsupported_out, reg_we_out, ptr_we_out, mem_we_out, flag_we_out});
            if (pend && e.reg_we) chk("reg", {e.reg_addr, e.reg_data, e.reg_byte},
                {reg_addr_out, reg_data_out, reg_byte_out});
            if (pend && e.ptr_we) chk("ptr", {e.ptr_addr, e.ptr_data},
                {ptr_addr_out, ptr_data_out});
            if (pend && e.mem_we) chk("mem", {e.mem_addr, e.mem_data, e.mem_byte},
                {mem_addr_out, mem_data_out, mem_byte_out});
            if (pend && e.flag_we) chk("flags", e.nzc, flags_nzc_out);
        end
    end

    // Main sequence: directed corners, then random traffic, then a second reset
    initial begin
        seed = 32'h80B9A2C4;
        {bad_count, n_compared, cycles} = '0;
        {resetn_in, instr_valid_in, instr_word_in, core_control_reg_in} = '0;
        {accumulator_a_in, accumulator_b_in, pend} = '0;
        repeat (8) @(posedge clock_in);
        resetn_in <= 1'h1;
        iss({8'hCD, 1'h0, 4'h0, 4'h4, 3'h0, 4'h5}, 40'h00_120F_FF00, r40(), 16'h0010);
        iss({8'hCD, 1'h1, 4'h0, 4'hC, 3'h3, 4'h5}, r40(), 40'hFF_F891_8F4C, 16'h0010);
        for (int i = 0; i < 64; i++)
            iss({8'hCD, i[0], 4'(i * 5), 4'(i), 3'(i * 3), 4'(i * 7)}, r40(), r40(),
                {10'h000, i[5], 3'h0, i[4], 1'h0});
        for (int j = 0; j < 16; j++)
            iss({8'hCD, 1'h0, 4'h0, 4'h0, 3'h0, 4'h2},
                j[3] ? {j[2] ? 8'h80 : 8'h7F, 32'h0000_0000} : {23'(j * 3), j[0], 16'h8000},
                r40(), {10'h000, j[2], 3'h0, j[1], 1'h0});
        for (int k = 0; k < 32; k++)
            iss({8'hFB, 5'h00, 4'(k * 3), 3'(k), 4'(k)}, r40(), r40(), 16'h0000);
        iss(24'hFB_8123, r40(), r40(), 16'h0000);
        for (int k = 0; k < 8; k++)
            iss({8'hEF, ~k[2], k[0], k[1], 13'(k * 517)}, r40(), r40(), 16'h0000);
        iss(24'h00_1234, r40(), r40(), 16'h0000);
        for (int i = 0; i < 600; i++) begin
            r = $random(seed);
            w = 24'($random(seed));
            w[23:16] = r[1] ? (r[0] ? 8'hEF : 8'hFB) : 8'hCD;
            if (w[23:16] == 8'hFB && r[4:2] != 3'h0) w[15:11] = 5'h00;
            if (w[23:16] == 8'hEF && r[4:2] != 3'h0) w[15] = 1'h1;
            if (r[6:5] == 2'h0) begin
                @(posedge clock_in);
                instr_valid_in <= 1'h0;
            end else iss(w, r40(), r40(), 16'($random(seed)));
        end
        @(posedge clock_in);
        instr_valid_in <= 1'h0;
        resetn_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        chk("reset", 83'h0, {done_out, unsupported_out, reg_we_out, reg_addr_out, reg_data_out,
            reg_byte_out, ptr_we_out, ptr_addr_out, ptr_data_out, mem_we_out, mem_addr_out,
            mem_data_out, mem_byte_out, flag_we_out, flags_nzc_out});
        @(posedge clock_in);
        resetn_in <= 1'h1;
        iss(24'hEF_E001, r40(), r40(), 16'h0000);
        iss({8'hFB, 5'h00, 4'h3, 3'h3, 4'h1}, r40(), r40(), 16'h0000);
        @(posedge clock_in);
        instr_valid_in <= 1'h0;
        repeat (3) @(posedge clock_in);
        complete_run();
    end
endmodule // acc_round_store_signext_fill_tb_top
